// ===== pkg/wfmr_pkg.sv
package wfmr_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int          IDX_W           = 7;
  localparam logic [6:0]  OFF_AMP_CFG     = 7'h33;
  localparam logic [6:0]  OFF_AMP_REF     = 7'h34;
  localparam logic [6:0]  OFF_AMP_AVG     = 7'h35;
  localparam logic [6:0]  OFF_AMP_LAST    = 7'h36;
  localparam logic [6:0]  OFF_PH_CFG      = 7'h37;
  localparam logic [6:0]  OFF_PH_REF      = 7'h38;
  localparam logic [6:0]  OFF_PH_AVG      = 7'h39;
  localparam logic [6:0]  OFF_PH_LAST     = 7'h3A;
  localparam logic [6:0]  OFF_DRV_RESTORE = 7'h38;
  localparam logic [6:0]  OFF_OSC_TRIM    = 7'h39;
  localparam logic [6:0]  SPACE_B_BASE    = 7'h40;
  localparam logic [6:0]  OFF_IRQ_STATUS  = 7'h50;
  localparam logic [6:0]  OFF_IRQ_MASK    = 7'h51;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          DRV_RESTORE_LSB = 4;
  localparam int          AVG_SHIFT_MIN   = 2;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [3:0]  RST_NIBBLE      = 4'h0;
  localparam logic [2:0]  RST_TRIM        = 3'h0;
  localparam logic [1:0]  RST_IRQ         = 2'h0;
  localparam int          CH_AMP          = 0;
  localparam int          CH_PHASE        = 1;
  localparam int          N_CH            = 2;

  // Channel configuration byte, MSB first
  typedef struct packed {
    logic [3:0] delta_threshold;
    logic       include_trigger;
    logic [1:0] average_weight;
    logic       reference_select;
  } wfmr_cfg_s;

  // One measurement from the analog front end
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } wfmr_meas_s;

endpackage

// ===== hdl/wfmr_top.sv
`timescale 1ns/1ps
`default_nettype none
module wfmr_top
  import wfmr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input  wire logic              CLOCK,
  input  wire logic              RST_N,
  input  wire logic              CLK_EN,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Measurement results
  input  wire wfmr_meas_s        MEAS_AMP,
  input  wire wfmr_meas_s        MEAS_PHASE,
  // Oscillator trim from the calibration block
  input  wire logic [2:0]        OSC_TRIM_CODE,
  // Transmitter timing and interrupt
  output logic      [3:0]        DRIVER_RESTORE_DELAY,
  output logic                   IRQ
);

  // Refuse an address bus too narrow for the register indices
  generate
    if (ADDR_W < IDX_W + 2) begin : g_addr_check
      $error("ADDR_W too small for the register map");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Moves the average toward the new value by (new - old) / 2^(weight + 2)
  function automatic logic [7:0] avg_step(input logic [7:0] old_v,
                                          input logic [7:0] new_v,
                                          input logic [1:0] wcode);
    logic signed [9:0] d;
    logic signed [9:0] s;
    logic        [9:0] sum;
    d   = $signed({2'b00, new_v}) - $signed({2'b00, old_v});
    s   = d >>> (AVG_SHIFT_MIN + int'(wcode));
    sum = {2'b00, old_v} + s;
    return sum[7:0];
  endfunction

  // Absolute difference of two bytes
  function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                          input logic [7:0] b);
    return (a >= b) ? (a - b) : (b - a);
  endfunction

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic              pready_r;
  logic              pslverr_r;
  logic [31:0]       prdata_r;
  logic [7:0]        rd_byte;
  logic              rd_hit;

  wire               acc_phase = PSEL && PENABLE;
  wire               acc_first = acc_phase && !pready_r;
  wire               acc_done  = acc_phase && pready_r;
  wire [IDX_W-1:0]   idx       = PADDR[IDX_W+1:2];
  wire               addr_ok   = (PADDR[1:0] == 2'b00) &&
                                 ((PADDR >> (IDX_W + 2)) == '0);
  wire               wr_go     = acc_done && PWRITE && !pslverr_r;
  wire [7:0]         wbyte     = PWDATA[7:0];

  wire               wr_amp_cfg = wr_go && (idx == OFF_AMP_CFG);
  wire               wr_amp_ref = wr_go && (idx == OFF_AMP_REF);
  wire               wr_ph_cfg  = wr_go && (idx == OFF_PH_CFG);
  wire               wr_ph_ref  = wr_go && (idx == OFF_PH_REF);
  wire               wr_drv     = wr_go && (idx == SPACE_B_BASE + OFF_DRV_RESTORE);
  wire               wr_stat    = wr_go && (idx == OFF_IRQ_STATUS);
  wire               wr_mask    = wr_go && (idx == OFF_IRQ_MASK);

  wire [N_CH-1:0]    wr_cfg = {wr_ph_cfg, wr_amp_cfg};
  wire [N_CH-1:0]    wr_ref = {wr_ph_ref, wr_amp_ref};

  // ---------------------------------------------------------------
  // Measurement channels
  // ---------------------------------------------------------------
  wfmr_meas_s        meas   [N_CH];
  wfmr_cfg_s         cfg_q  [N_CH];
  logic [7:0]        ref_q  [N_CH];
  logic [7:0]        avg_q  [N_CH];
  logic [7:0]        last_q [N_CH];
  logic [N_CH-1:0]   hit;

  assign meas[CH_AMP]   = MEAS_AMP;
  assign meas[CH_PHASE] = MEAS_PHASE;

  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      wfmr_cfg_s   cfg_r;
      logic [7:0]  ref_r;
      logic [7:0]  avg_r;
      logic [7:0]  last_r;

      // Reference: software value or running average
      wire [7:0] cmp_ref = cfg_r.reference_select ? avg_r : ref_r;
      wire       trig    = meas[g].valid &&
                           (abs_diff(meas[g].value, cmp_ref) >
                            {4'h0, cfg_r.delta_threshold});
      wire       admit   = meas[g].valid &&
                           (!trig || cfg_r.include_trigger);
      wire [7:0] avg_nxt = avg_step(avg_r, meas[g].value, cfg_r.average_weight);

      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          cfg_r  <= wfmr_cfg_s'(RST_BYTE);
          ref_r  <= RST_BYTE;
        end else if (CLK_EN) begin
          if (wr_cfg[g]) begin
            cfg_r <= wfmr_cfg_s'(wbyte);
          end
          if (wr_ref[g]) begin
            ref_r <= wbyte;
          end
        end
      end

      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          avg_r  <= RST_BYTE;
          last_r <= RST_BYTE;
        end else if (CLK_EN) begin
          if (meas[g].valid) begin
            last_r <= meas[g].value;
          end
          if (admit) begin
            avg_r <= avg_nxt;
          end
        end
      end

      assign cfg_q[g]  = cfg_r;
      assign ref_q[g]  = ref_r;
      assign avg_q[g]  = avg_r;
      assign last_q[g] = last_r;
      assign hit[g]    = trig;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Edge timing and oscillator trim
  // ---------------------------------------------------------------
  logic [3:0]  drv_restore_r;
  logic [2:0]  trim_s1_r;
  logic [2:0]  trim_s2_r;
  logic [2:0]  trim_s3_r;
  logic [2:0]  trim_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      drv_restore_r <= RST_NIBBLE;
    end else if (CLK_EN && wr_drv) begin
      // Low reserved bits are not stored and read back as zero
      drv_restore_r <= wbyte[DRV_RESTORE_LSB +: 4];
    end
  end

  // Trim code settles only when the last two stages agree
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      trim_s1_r <= RST_TRIM;
      trim_s2_r <= RST_TRIM;
      trim_s3_r <= RST_TRIM;
      trim_r    <= RST_TRIM;
    end else if (CLK_EN) begin
      trim_s1_r <= OSC_TRIM_CODE;
      trim_s2_r <= trim_s1_r;
      trim_s3_r <= trim_s2_r;
      if (trim_s2_r == trim_s3_r) begin
        trim_r <= trim_s3_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic        irq_r;

  // Set wins over a write-one-to-clear in the same cycle
  wire [1:0] stat_clr = wr_stat ? wbyte[1:0] : 2'b00;
  wire [1:0] stat_nxt = (irq_stat_r & ~stat_clr) | hit;
  wire [1:0] mask_nxt = wr_mask ? wbyte[1:0] : irq_mask_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      irq_stat_r <= RST_IRQ;
      irq_mask_r <= RST_IRQ;
      irq_r      <= 1'b0;
    end else if (CLK_EN) begin
      irq_stat_r <= stat_nxt;
      irq_mask_r <= mask_nxt;
      irq_r      <= |(stat_nxt & mask_nxt);
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = RST_BYTE;
    case (idx)
      OFF_AMP_CFG:                    rd_byte = cfg_q[CH_AMP];
      OFF_AMP_REF:                    rd_byte = ref_q[CH_AMP];
      OFF_AMP_AVG:                    rd_byte = avg_q[CH_AMP];
      OFF_AMP_LAST:                   rd_byte = last_q[CH_AMP];
      OFF_PH_CFG:                     rd_byte = cfg_q[CH_PHASE];
      OFF_PH_REF:                     rd_byte = ref_q[CH_PHASE];
      OFF_PH_AVG:                     rd_byte = avg_q[CH_PHASE];
      OFF_PH_LAST:                    rd_byte = last_q[CH_PHASE];
      SPACE_B_BASE + OFF_DRV_RESTORE: rd_byte = {drv_restore_r, 4'h0};
      SPACE_B_BASE + OFF_OSC_TRIM:    rd_byte = {5'h00, trim_r};
      OFF_IRQ_STATUS:                 rd_byte = {6'h00, irq_stat_r};
      OFF_IRQ_MASK:                   rd_byte = {6'h00, irq_mask_r};
      default:                        rd_hit  = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // APB response: one wait state, writes land on the ready edge
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (CLK_EN) begin
      if (acc_first) begin
        pready_r  <= 1'b1;
        pslverr_r <= !(addr_ok && rd_hit);
        prdata_r  <= (addr_ok && rd_hit && !PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end else begin
        pready_r  <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r  <= 32'h0000_0000;
      end
    end
  end

  assign PREADY               = pready_r;
  assign PSLVERR              = pslverr_r;
  assign PRDATA               = prdata_r;
  assign DRIVER_RESTORE_DELAY = drv_restore_r;
  assign IRQ                  = irq_r;

endmodule
`default_nettype wire

// ===== testbench/wfmr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module wfmr_checker
  import wfmr_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              CLOCK,
  input wire logic              RST_N,
  input wire logic              CLK_EN,
  // APB
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  // Measurements and outputs
  input wire wfmr_meas_s        MEAS_AMP,
  input wire wfmr_meas_s        MEAS_PHASE,
  input wire logic [3:0]        DRIVER_RESTORE_DELAY,
  input wire logic              IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N || !CLK_EN);
  sequence acc_start;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence drv_write;
    PREADY && PWRITE && !PSLVERR && PADDR == ADDR_W'({SPACE_B_BASE + OFF_DRV_RESTORE, 2'h0});
  endsequence
  a_one_wait: assert property (acc_start |=> PREADY) else $error("access not answered after one wait");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_ready_access: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0) else $error("read data outside ready");
  a_rdata_upper: assert property (PRDATA[31:8] == 24'h0) else $error("upper read data not zero");
  a_err_align: assert property (acc_start and PADDR[1:0] != 2'h0 |=> PREADY && PSLVERR)
    else $error("misaligned access not refused");
  a_irq_cause: assert property ($rose(IRQ) |->
    $past(MEAS_AMP.valid || MEAS_PHASE.valid || (PREADY && PWRITE)))
    else $error("interrupt rose without a cause");
  a_irq_clear: assert property ($fell(IRQ) |-> $past(PREADY && PWRITE))
    else $error("interrupt fell without write");
  a_drv_load: assert property (drv_write |=> DRIVER_RESTORE_DELAY == $past(PWDATA[7:4]))
    else $error("restore delay not loaded");
  a_drv_hold: assert property (!(PREADY && PWRITE) |=> $stable(DRIVER_RESTORE_DELAY))
    else $error("restore delay changed without write");
endmodule
bind wfmr_top wfmr_checker #(.ADDR_W(ADDR_W)) u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(CLK_EN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .MEAS_AMP(MEAS_AMP), .MEAS_PHASE(MEAS_PHASE),
  .DRIVER_RESTORE_DELAY(DRIVER_RESTORE_DELAY), .IRQ(IRQ));
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import wfmr_pkg::*;
;
  localparam logic [6:0] IDX_DRV  = SPACE_B_BASE + OFF_DRV_RESTORE;
  localparam logic [6:0] IDX_TRIM = SPACE_B_BASE + OFF_OSC_TRIM;
  logic             CLOCK = 1'b0;
  logic             RST_N = 1'b0;
  logic             CLK_EN = 1'b1;
  logic             PSEL = 1'b0;
  logic             PENABLE = 1'b0;
  logic             PWRITE = 1'b0;
  logic [11:0]      PADDR = 12'h000;
  logic [31:0]      PWDATA = 32'h0;
  logic [2:0]       OSC_TRIM_CODE = 3'h0;
  wfmr_meas_s       MEAS_AMP = '0;
  wfmr_meas_s       MEAS_PHASE = '0;
  logic [31:0]      PRDATA;
  logic             PREADY;
  logic             PSLVERR;
  logic             IRQ;
  logic [3:0]       DRIVER_RESTORE_DELAY;
  logic [9:0]       exp_q[$];
  logic [9:0]       got;
  logic [1:0][7:0]  avg = '0, last = '0, ref_v = '0, cfg = '0;
  logic [1:0]       status = 2'h0, mask = 2'h0;
  logic [6:0]       reg_idx[12] = '{OFF_AMP_CFG, OFF_AMP_REF, OFF_AMP_AVG, OFF_AMP_LAST, OFF_PH_CFG, OFF_PH_REF,
                                    OFF_PH_AVG, OFF_PH_LAST, IDX_DRV, IDX_TRIM, OFF_IRQ_STATUS, OFF_IRQ_MASK};
  int               failures = 0;
  int               num_checks = 0;
  int               ch;

  wfmr_top dut (.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEAS_AMP(MEAS_AMP),
    .MEAS_PHASE(MEAS_PHASE), .OSC_TRIM_CODE(OSC_TRIM_CODE), .DRIVER_RESTORE_DELAY(DRIVER_RESTORE_DELAY), .IRQ(IRQ));

  initial begin
    forever #50 CLOCK = ~CLOCK;
  end

  // ----------------------------------------
  // Compare and closing tasks
  // ----------------------------------------
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  // Read expectations: {check data, error, data}; writes skip the data
  task automatic apb(input logic w, input logic [6:0] idx, input logic [7:0] d, input logic er = 1'b0,
                     input logic [1:0] lo = 2'h0);
    int n;
    n = 0;
    exp_q.push_back({~w, er, d});
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {3'h0, idx, lo};
    PWDATA <= {24'($urandom), d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic idle(input int n);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    repeat (n) @(posedge CLOCK);
  endtask

  task automatic meas(input int c, input logic [7:0] v);
    int d;
    logic trig;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (c == CH_AMP) MEAS_AMP <= {1'b1, v};
    else MEAS_PHASE <= {1'b1, v};
    d = int'(v) - int'(cfg[c][0] ? avg[c] : ref_v[c]);
    trig = (d < 0 ? -d : d) > int'(cfg[c][7:4]);
    if (!trig || cfg[c][3]) avg[c] = 8'(int'(avg[c]) + ((int'(v) - int'(avg[c])) >>> (2 + cfg[c][2:1])));
    last[c] = v;
    status[c] = status[c] | trig;
    @(posedge CLOCK);
    MEAS_AMP.valid <= 1'b0;
    MEAS_PHASE.valid <= 1'b0;
  endtask

  always @(posedge CLOCK) begin
    if (PREADY === 1'b1) begin
      got = exp_q.size() > 0 ? exp_q.pop_front() : 10'h3FF;
      chk1("PSLVERR", got[8], PSLVERR);
      if (got[9]) chk32("PRDATA", {24'h0, got[7:0]}, PRDATA);
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(24734));
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    foreach (reg_idx[i]) apb(1'b0, reg_idx[i], 8'h00);
    apb(1'b0, 7'h20, 8'h00, 1'b1);
    apb(1'b1, OFF_PH_REF, 8'hFF, 1'b1, 2'h1);
    apb(1'b1, OFF_AMP_AVG, 8'h5A);
    apb(1'b0, OFF_PH_REF, 8'h00);
    apb(1'b0, OFF_AMP_AVG, 8'h00);
    apb(1'b1, IDX_DRV, 8'hA0);
    apb(1'b0, IDX_DRV, 8'hA0);
    chk32("DRIVER_RESTORE_DELAY", 32'h0000_000A, {28'h000_0000, DRIVER_RESTORE_DELAY});
    apb(1'b1, IDX_DRV, 8'h00);
    idle(1);
    chk32("DRIVER_RESTORE_DELAY", 32'h0000_0000, {28'h000_0000, DRIVER_RESTORE_DELAY});
    for (int i = 0; i < 8; i++) begin
      OSC_TRIM_CODE <= 3'(i);
      idle(6);
      apb(1'b0, IDX_TRIM, {5'h00, 3'(i)});
    end
    // A measurement while the clock enable is low must change nothing
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    CLK_EN <= 1'b0;
    MEAS_AMP <= {1'b1, 8'hC3};
    @(posedge CLOCK);
    MEAS_AMP.valid <= 1'b0;
    CLK_EN <= 1'b1;
    @(posedge CLOCK);
    apb(1'b0, OFF_AMP_LAST, last[0]);
    apb(1'b0, OFF_IRQ_STATUS, 8'h00);
    for (int i = 0; i < 48; i++) begin
      ch = i % 2;
      mask = 2'($urandom);
      cfg[ch] = 8'($urandom);
      ref_v[ch] = 8'($urandom);
      apb(1'b1, OFF_IRQ_MASK, {6'h00, mask});
      apb(1'b1, ch ? OFF_PH_CFG : OFF_AMP_CFG, cfg[ch]);
      apb(1'b1, ch ? OFF_PH_REF : OFF_AMP_REF, ref_v[ch]);
      meas(ch, (cfg[ch][0] ? avg[ch] : ref_v[ch]) + 8'($urandom_range(30)) - 8'h0F);
      apb(1'b0, ch ? OFF_PH_LAST : OFF_AMP_LAST, last[ch]);
      apb(1'b0, ch ? OFF_PH_AVG : OFF_AMP_AVG, avg[ch]);
      apb(1'b0, OFF_IRQ_STATUS, {6'h00, status});
      chk1("IRQ", |(status & mask), IRQ);
      apb(1'b1, OFF_IRQ_STATUS, {6'h00, status});
      status = 2'h0;
    end
    idle(3);
    chk1("IRQ", 1'b0, IRQ);
    stop_test();
  end
endmodule
`default_nettype wire
